/* File: rtl/dsc_defines.vh */
// timing counts and reset values for the delta-sigma converter control
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH
`define DSC_MCLK_MHZ        125
`define DSC_CONV_CYCLES     12'd2640
`define DSC_FIRST_DELAY     10'd674
`define DSC_MOD_SETTLE      3'd5
`define DSC_DIV_RST         2'h0
`define DSC_RESULT_RST      24'h000000
`endif

/* File: rtl/dsc_clkdiv.v */
// conversion clock enable divider: source clock / 1, 2, 4 or 8
`timescale 1ns/1ps
module dsc_clkdiv (
  mclk,
  rst_b,
  div_sel,
  run,
  tick
);
  input  wire       mclk;
  input  wire       rst_b;
  input  wire [1:0] div_sel;
  input  wire       run;
  output reg        tick;

  reg  [2:0] cnt_reg;
  wire [2:0] top;

  assign top = (div_sel == 2'h0) ? 3'h0 : (div_sel == 2'h1) ? 3'h1 : (div_sel == 2'h2) ? 3'h3 : 3'h7;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
      tick    <= 1'b0;
    end else if (!run) begin
      // gated clock stops the divider and clears its count
      cnt_reg <= 3'h0;
      tick    <= 1'b0;
    end else if (cnt_reg >= top) begin
      cnt_reg <= 3'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      tick    <= 1'b0;
    end
  end
endmodule // dsc_clkdiv

/* File: rtl/dsc_control.v */
// delta-sigma converter control: sequencing, start, status and result flags
`timescale 1ns/1ps
`include "dsc_defines.vh"
module dsc_control #(
  parameter DATA_W = 24,
  parameter OFS_W  = 8
) (
  mclk,
  rst_b,
  converter_clock_gate,
  conversion_clock_divider,
  bias_enable,
  modulator_enable,
  conversion_go,
  master_go,
  repeat_mode,
  sync_slave_select,
  start_delay_enable,
  start_delay_offset,
  status_read,
  result_read,
  mod_data_valid,
  mod_data,
  conv_busy_flag,
  conv_end_flag,
  result_valid_flag,
  result_overrun_flag,
  converter_result,
  conv_end_irq,
  conv_start_out
);
  input  wire              mclk;
  input  wire              rst_b;
  input  wire              converter_clock_gate;
  input  wire [1:0]        conversion_clock_divider;
  input  wire              bias_enable;
  input  wire              modulator_enable;
  input  wire              conversion_go;
  input  wire              master_go;
  input  wire              repeat_mode;
  input  wire              sync_slave_select;
  input  wire              start_delay_enable;
  input  wire [OFS_W-1:0]  start_delay_offset;
  input  wire              status_read;
  input  wire              result_read;
  input  wire              mod_data_valid;
  input  wire [DATA_W-1:0] mod_data;
  output reg               conv_busy_flag;
  output reg               conv_end_flag;
  output reg               result_valid_flag;
  output reg               result_overrun_flag;
  output reg  [DATA_W-1:0] converter_result;
  output reg               conv_end_irq;
  output reg               conv_start_out;

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_DELAY = 4'b0010;
  localparam ST_ALIGN = 4'b0100;
  localparam ST_CONV  = 4'b1000;

  reg  [3:0]        state_reg;
  reg  [3:0]        state_next;
  reg  [11:0]       cnt_reg;
  reg  [11:0]       cnt_next;
  reg  [OFS_W-1:0]  ofs_reg;
  reg  [OFS_W-1:0]  ofs_next;
  reg               first_reg;
  reg               first_next;
  reg  [2:0]        settle_reg;
  reg               go_d_reg;
  reg               mgo_meta_reg;
  reg               mgo_sync_reg;
  reg               mgo_d_reg;
  reg               rep_seen_reg;
  reg               finish;
  reg               abort;
  wire              tick;
  wire              ready;
  wire              start_req;
  wire [11:0]       conv_len;

  // ----------------------------------------
  // conversion clock
  // ----------------------------------------
  // divided enable; divider only changes while powered down
  dsc_clkdiv u_div (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .div_sel (conversion_clock_divider),
    .run     (~converter_clock_gate),
    .tick    (tick)
  );

  // five conversion clocks of settling after modulator enable
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= 3'h0;
    end else if (!modulator_enable || !bias_enable) begin
      settle_reg <= 3'h0;
    end else if (tick && settle_reg != `DSC_MOD_SETTLE) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end
  assign ready = (settle_reg == `DSC_MOD_SETTLE);

  // ----------------------------------------
  // start sources
  // ----------------------------------------
  // master start crosses from another unit, so two flops first
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      go_d_reg     <= 1'b0;
      mgo_meta_reg <= 1'b0;
      mgo_sync_reg <= 1'b0;
      mgo_d_reg    <= 1'b0;
    end else begin
      go_d_reg     <= conversion_go;
      mgo_meta_reg <= master_go;
      mgo_sync_reg <= mgo_meta_reg;
      mgo_d_reg    <= mgo_sync_reg;
    end
  end
  // own start edge; slave follows master start
  assign start_req = sync_slave_select ? (mgo_sync_reg & ~mgo_d_reg) : (conversion_go & ~go_d_reg);

  // first conversion carries the fixed delay
  assign conv_len = first_reg ? (`DSC_CONV_CYCLES + {2'b00, `DSC_FIRST_DELAY}) : `DSC_CONV_CYCLES;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ofs_next   = ofs_reg;
    first_next = first_reg;
    finish     = 1'b0;
    abort      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_req && ready) begin
          first_next = 1'b1;
          cnt_next   = 12'h000;
          ofs_next   = start_delay_offset;
          if (start_delay_enable && start_delay_offset != {OFS_W{1'b0}}) begin
            state_next = ST_DELAY;
          end else begin
            state_next = ST_ALIGN;
          end
        end
      end
      ST_DELAY: begin
        ofs_next = ofs_reg - {{(OFS_W-1){1'b0}}, 1'b1};
        if (ofs_reg == {{(OFS_W-1){1'b0}}, 1'b1}) begin
          state_next = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (tick) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tick) begin
          cnt_next = cnt_reg + 12'h001;
        end
        if (tick && cnt_reg + 12'h001 == conv_len) begin
          finish     = 1'b1;
          cnt_next   = 12'h000;
          first_next = 1'b0;
          if (!repeat_mode) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // repeat dropped mid-run: abort, no end event
    abort = (state_reg != ST_IDLE) && rep_seen_reg && !repeat_mode;
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg           <= ST_IDLE;
      cnt_reg             <= 12'h000;
      ofs_reg             <= {OFS_W{1'b0}};
      first_reg           <= 1'b0;
      rep_seen_reg        <= 1'b0;
      conv_busy_flag      <= 1'b0;
      conv_end_flag       <= 1'b0;
      result_valid_flag   <= 1'b0;
      result_overrun_flag <= 1'b0;
      converter_result    <= `DSC_RESULT_RST;
      conv_end_irq        <= 1'b0;
      conv_start_out      <= 1'b0;
    end else begin
      conv_start_out <= start_req & ready & (state_reg == ST_IDLE);
      // run counts as repeat once the mode bit is seen high
      rep_seen_reg   <= (state_reg == ST_IDLE) ? repeat_mode : (rep_seen_reg | repeat_mode);
      // mode cleared during a repeat run aborts silently
      if (abort) begin
        state_reg      <= ST_IDLE;
        cnt_reg        <= 12'h000;
        first_reg      <= 1'b0;
        conv_end_irq   <= 1'b0;
        conv_busy_flag <= 1'b0;
      end else begin
        state_reg    <= state_next;
        cnt_reg      <= cnt_next;
        ofs_reg      <= ofs_next;
        first_reg    <= first_next;
        conv_end_irq <= finish;
        conv_busy_flag <= (state_next != ST_IDLE);
      end
      if (finish && !abort) begin
        conv_end_flag <= 1'b1;
      end else if (status_read) begin
        conv_end_flag <= 1'b0;
      end
      if (finish && !abort) begin
        converter_result    <= mod_data_valid ? mod_data : converter_result;
        result_valid_flag   <= 1'b1;
        result_overrun_flag <= result_valid_flag & ~result_read | result_overrun_flag & ~result_read;
      end else if (result_read) begin
        result_valid_flag   <= 1'b0;
        result_overrun_flag <= 1'b0;
      end
    end
  end
endmodule // dsc_control

/* File: test/dsc_control_assertions.sv */
// port checks for the converter control
`timescale 1ns/1ps
module dsc_control_assertions (
  input wire        mclk,
  input wire        rst_b,
  input wire        conversion_go,
  input wire        repeat_mode,
  input wire        sync_slave_select,
  input wire        status_read,
  input wire        result_read,
  input wire        conv_busy_flag,
  input wire        conv_end_flag,
  input wire        result_valid_flag,
  input wire        result_overrun_flag,
  input wire        conv_end_irq,
  input wire        conv_start_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // cycles since last start or end, saturating
  reg [15:0] cyc_reg;
  always @(posedge mclk or negedge rst_b)
    if (!rst_b) cyc_reg <= 16'h0000;
    else if (conv_start_out || conv_end_irq) cyc_reg <= 16'h0000;
    else if (cyc_reg != 16'hffff) cyc_reg <= cyc_reg + 16'h0001;
  property p_start; conv_start_out |-> conv_busy_flag; endproperty
  a_start: assert property (p_start) else $error("start without busy");
  property p_flags; conv_end_irq |-> conv_end_flag && result_valid_flag; endproperty
  a_flags: assert property (p_flags) else $error("end flags missing");
  property p_len; conv_end_irq |-> cyc_reg >= 16'd2639; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_single; conv_end_irq && !repeat_mode && !$past(repeat_mode) |-> !conv_busy_flag; endproperty
  a_single: assert property (p_single) else $error("single run kept busy");
  property p_hold; conv_end_irq && repeat_mode |-> conv_busy_flag; endproperty
  a_hold: assert property (p_hold) else $error("repeat dropped busy");
  property p_stat; status_read |=> !conv_end_flag || conv_end_irq; endproperty
  a_stat: assert property (p_stat) else $error("end flag not cleared");
  property p_rclr; result_read |=> (!result_valid_flag && !result_overrun_flag) || conv_end_irq; endproperty
  a_rclr: assert property (p_rclr) else $error("result flags not cleared");
  property p_ovr; conv_end_irq && $past(result_valid_flag) && !$past(result_read) |-> result_overrun_flag; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missing");
  property p_abort; $fell(repeat_mode) && conv_busy_flag |=> !conv_busy_flag && !conv_end_irq; endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_slave; sync_slave_select && $rose(conversion_go) && !conv_busy_flag |=> !conv_start_out; endproperty
  a_slave: assert property (p_slave) else $error("slave took own start");
  c_end: cover property (conv_end_irq && repeat_mode);
  c_ovr: cover property (conv_end_irq && result_overrun_flag);
  c_abort: cover property ($fell(repeat_mode) && conv_busy_flag);
endmodule // dsc_control_assertions
bind dsc_control dsc_control_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .conversion_go(conversion_go),
  .repeat_mode(repeat_mode), .sync_slave_select(sync_slave_select), .status_read(status_read),
  .result_read(result_read), .conv_busy_flag(conv_busy_flag), .conv_end_flag(conv_end_flag),
  .result_valid_flag(result_valid_flag), .result_overrun_flag(result_overrun_flag),
  .conv_end_irq(conv_end_irq), .conv_start_out(conv_start_out));

/* File: test/dsc_control_tb_top.sv */
// self-checking bench for the converter control
`timescale 1ns/1ps
module dsc_control_tb_top;
  reg         mclk, rst_b, cg, bias, modu, go, mgo, rep, slv, dly, sr, rr, s0;
  reg  [1:0]  div;
  reg  [7:0]  ofs;
  reg  [23:0] md;
  wire        busy, endf, rv, ovr, irq, so;
  wire [23:0] res;
  integer     err_total, checks, n;
  dsc_control u_dsc_control (.mclk(mclk), .rst_b(rst_b), .converter_clock_gate(cg),
    .conversion_clock_divider(div), .bias_enable(bias), .modulator_enable(modu), .conversion_go(go),
    .master_go(mgo), .repeat_mode(rep), .sync_slave_select(slv), .start_delay_enable(dly),
    .start_delay_offset(ofs), .status_read(sr), .result_read(rr), .mod_data_valid(1'b1), .mod_data(md),
    .conv_busy_flag(busy), .conv_end_flag(endf), .result_valid_flag(rv), .result_overrun_flag(ovr),
    .converter_result(res), .conv_end_irq(irq), .conv_start_out(so));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rng(input [31:0] g, input [31:0] lo, input [31:0] hi);
    begin
      checks = checks + 1;
      if (g < lo || g > hi) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, lo);
      end
    end
  endtask
  // cycles until end pulse, bounded
  task wt(input integer lim);
    begin
      n = 1;
      @(negedge mclk);
      go = 1'b0;
      s0 = so;
      while (irq !== 1'b1 && n < lim) begin
        @(negedge mclk);
        n = n + 1;
      end
    end
  endtask
  task run(input integer lim);
    begin
      go = 1'b1;
      wt(lim);
    end
  endtask
  task pulse_rd(input integer which);
    begin
      if (which == 0) sr = 1'b1; else rr = 1'b1;
      @(negedge mclk);
      sr = 1'b0;
      rr = 1'b0;
      @(negedge mclk);
    end
  endtask
  // ordered power-down, divider changed while off
  task redivide(input [1:0] d);
    begin
      modu = 1'b0;
      repeat (8) @(negedge mclk);
      bias = 1'b0;
      @(negedge mclk);
      cg  = 1'b1;
      div = d;
      @(negedge mclk);
      cg  = 1'b0;
      @(negedge mclk);
      bias = 1'b1;
      @(negedge mclk);
      modu = 1'b1;
      repeat (80) @(negedge mclk);
    end
  endtask
  task end_of_test;
    begin
      $display("err_total %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // ----------------------------------------
  // watchdog: about 66k cycles expected
  // ----------------------------------------
  initial begin
    #720000;
    err_total = err_total + 1;
    end_of_test;
  end
  initial begin
    {rst_b, cg, bias, modu, go, mgo, rep, slv, dly, sr, rr} = 11'h000;
    div = 2'h0;
    ofs = 8'h00;
    md = 24'h5a5a5a;
    err_total = 0;
    checks = 0;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    chk({busy, endf, rv, ovr, irq, so, res}, 32'h0);
    bias = 1'b1;
    @(negedge mclk);
    modu = 1'b1;
    @(negedge mclk);
    run(3);
    chk({busy, s0}, 2'h0);
    repeat (10) @(negedge mclk);
    run(4000);
    rng(n, 3314, 3322);
    chk(s0, 1'b1);
    chk({rv, ovr, res}, {2'h2, md});
    @(negedge mclk);
    chk({busy, endf}, 2'h1);
    pulse_rd(0);
    chk(endf, 1'b0);
    rep = 1'b1;
    md = 24'h123456;
    run(4000);
    chk({busy, ovr, res}, {2'h3, md});
    wt(3000);
    chk(n, 2640);
    chk(busy, 1'b1);
    pulse_rd(1);
    chk({rv, ovr}, 2'h0);
    repeat (100) @(negedge mclk);
    rep = 1'b0;
    wt(3000);
    chk({busy, n[15:0]}, 17'd3000);
    slv = 1'b1;
    run(100);
    chk({busy, s0}, 2'h0);
    mgo = 1'b1;
    wt(4000);
    rng(n, 3315, 3326);
    {mgo, slv, dly, ofs} = {3'h1, 8'h14};
    @(negedge mclk);
    run(4000);
    rng(n, 3334, 3344);
    dly = 1'b0;
    redivide(2'h1);
    run(8000);
    rng(n, 6628, 6644);
    redivide(2'h2);
    run(14000);
    rng(n, 13254, 13266);
    redivide(2'h3);
    run(28000);
    rng(n, 26506, 26530);
    end_of_test;
  end
endmodule // dsc_control_tb_top
